// ==== hw/stndc_pkg.sv ====
package stndc_pkg;
  // ----------------------------------------------------------------
  // geometry and field widths
  // ----------------------------------------------------------------
  localparam int STNDC_ROWS = 160;
  localparam int STNDC_ROW_W = 8;
  localparam logic [7:0] STNDC_MUX_FULL = 8'ha0;

  // ----------------------------------------------------------------
  // line rate scaling thresholds
  // ----------------------------------------------------------------
  localparam logic [7:0] STNDC_THR_109 = 8'h6d;
  localparam logic [7:0] STNDC_THR_108 = 8'h6c;
  localparam logic [7:0] STNDC_THR_80 = 8'h50;
  localparam logic [7:0] STNDC_THR_56 = 8'h38;
  localparam logic [7:0] STNDC_THR_40 = 8'h28;
  // divisors expressed in half steps (x2): 1, 1.5, 2, 3, 4
  localparam logic [3:0] STNDC_DIV2_1 = 4'h2;
  localparam logic [3:0] STNDC_DIV2_15 = 4'h3;
  localparam logic [3:0] STNDC_DIV2_2 = 4'h4;
  localparam logic [3:0] STNDC_DIV2_3 = 4'h6;
  localparam logic [3:0] STNDC_DIV2_4 = 4'h8;
  // extra divide applied in on/off modulation mode
  localparam logic [3:0] STNDC_ONOFF_MUL = 4'h2;

  // ----------------------------------------------------------------
  // base line periods in system clocks for the four line rate codes
  // ----------------------------------------------------------------
  localparam logic [11:0] STNDC_LINE_P0 = 12'h1e0;
  localparam logic [11:0] STNDC_LINE_P1 = 12'h190;
  localparam logic [11:0] STNDC_LINE_P2 = 12'h154;
  localparam logic [11:0] STNDC_LINE_P3 = 12'h10e;

  // ----------------------------------------------------------------
  // bias ratios and temperature coefficients (x100 percent per degree)
  // ----------------------------------------------------------------
  localparam logic [3:0] STNDC_BIAS_0 = 4'h5;
  localparam logic [3:0] STNDC_BIAS_1 = 4'ha;
  localparam logic [3:0] STNDC_BIAS_2 = 4'hb;
  localparam logic [3:0] STNDC_BIAS_3 = 4'hc;
  localparam logic [4:0] STNDC_TC_0 = 5'h00;
  localparam logic [4:0] STNDC_TC_1 = 5'h05;
  localparam logic [4:0] STNDC_TC_2 = 5'h0f;
  localparam logic [4:0] STNDC_TC_3 = 5'h19;

  // ----------------------------------------------------------------
  // power sequence timing
  // ----------------------------------------------------------------
  localparam int STNDC_CLK_MHZ = 10;
  localparam int STNDC_WAKE_US = 20;
  localparam int STNDC_SUPPLY_US = 100;
  localparam int STNDC_WAKE_CYC = STNDC_WAKE_US * STNDC_CLK_MHZ;
  localparam int STNDC_SUPPLY_CYC = STNDC_SUPPLY_US * STNDC_CLK_MHZ;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic STNDC_RST_COLOR_16 = 1'b1;

  typedef enum logic [1:0] {
    STNDC_SLEEP,
    STNDC_WAKE,
    STNDC_SUPPLY,
    STNDC_ACTIVE
  } stndc_pwr_e;
endpackage

// ==== hw/stndc_color_conv.sv ====
// pixel write path: 12-bit or 16-bit input into the 5-6-5 RAM word
module stndc_color_conv
  import stndc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic color_12bit_mode,
  input wire logic wr_valid,
  input wire logic [15:0] wr_pixel,
  output logic ram_we,
  output logic [15:0] ram_word
);
  // ----------------------------------------------------------------
  // conversion
  // ----------------------------------------------------------------
  logic [15:0] conv;
  logic next_ram_we;
  logic [15:0] next_ram_word;

  // widen each 4-bit component by copying its top bits downward
  always_comb begin
    conv = {wr_pixel[11:8], wr_pixel[11],
            wr_pixel[7:4], wr_pixel[7:6],
            wr_pixel[3:0], wr_pixel[3]};
    next_ram_we = wr_valid;
    // mode sampled per write only, stored words are never revisited
    next_ram_word = color_12bit_mode ? conv : wr_pixel;
  end

  // register the write toward the RAM
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ram_we <= 1'b0;
      ram_word <= 16'h0000;
    end else begin
      ram_we <= next_ram_we;
      ram_word <= next_ram_word;
    end
  end

  AST_CONV_565: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_valid && color_12bit_mode |=> ram_word[4:0] == {$past(wr_pixel[3:0]), $past(wr_pixel[3])})
    else $error("12-bit blue extension wrong");
  AST_CONV_DIRECT: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_valid && !color_12bit_mode |=> ram_we && ram_word == $past(wr_pixel))
    else $error("16-bit word not stored directly");
endmodule

// ==== hw/stndc_seg_out.sv ====
// column data path: all-on, invert and idle shorting of the columns
module stndc_seg_out
  import stndc_pkg::*;
#(
  parameter int COLS = 8
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic drivers_on,
  input wire logic all_on_flag,
  input wire logic invert_flag,
  input wire logic [COLS-1:0] ram_data,
  output logic [COLS-1:0] column_driver,
  output logic column_short
);
  // ----------------------------------------------------------------
  // per column select
  // ----------------------------------------------------------------
  logic [COLS-1:0] next_col;

  // enable overrides both flags; RAM data is only read, never written
  genvar g;
  generate
    for (g = 0; g < COLS; g++) begin : g_col
      assign next_col[g] = !drivers_on ? 1'b0 :
                           all_on_flag ? 1'b1 :
                           ram_data[g] ^ invert_flag;
    end
  endgenerate

  // idle columns are tied together for zero DC
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      column_driver <= '0;
      column_short <= 1'b1;
    end else begin
      column_driver <= next_col;
      column_short <= !drivers_on;
    end
  end

  AST_SEG_ALLON: assert property (@(posedge sys_clk) disable iff (!rstn)
    drivers_on && all_on_flag |=> &column_driver)
    else $error("all-on not forcing columns");
  AST_SEG_INV: assert property (@(posedge sys_clk) disable iff (!rstn)
    drivers_on && !all_on_flag && invert_flag |=> column_driver == ~$past(ram_data))
    else $error("invert output wrong");
  AST_SEG_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn)
    !drivers_on |=> column_short && column_driver == '0)
    else $error("idle columns not shorted");
endmodule

// ==== hw/stndc_top.sv ====
// Behaviour
// - two-bit bias select maps codes 0..3 to bias ratios 5, 10, 11, 12
// - two-bit temp select picks 0, -0.05, -0.15, -0.25 percent per degree
// - pump source bit chooses internal charge pump or external high supply
// - internal drive level set from bias, 8-bit contrast trim, temp select
// - two-bit line rate field picks one of four line rates
// - mux above 109: frames at line rate over mux, no scaling
// - mux at 108, 80, 56, 40 divides line rate by 1.5, 2, 3, 4
// - on/off modulation mode lowers the line rate further
// - enable bit sets drivers idle or active; idle columns tied together
// - clearing enable idles drivers and enters sleep
// - setting enable: leave sleep, restore supplies, then drive rows and columns
// - driver enable overrides all-on and invert flags
// - all-on with drivers enabled forces every column on, RAM untouched
// - invert flag outputs bit-wise inverse of RAM data
// - fixed top and bottom rows excluded from scroll offset
// - each of 160 row drivers maps to a fixed panel row
// - two software-selectable modes: 32-shade and on/off
// - switching modulation mode never alters RAM contents
// - 12-bit input extended to 5-6-5 before storing
// - 16-bit input is reset default, stored directly as 5-6-5
// - changing input color mode leaves stored RAM data alone
// - timing runs from internal clock, no external components
// - partial display shrinks mux to span, plus fixed rows times two when scroll bit set
module stndc_top
  import stndc_pkg::*;
#(
  parameter int COLS = 8,
  parameter int WAKE_CYC = STNDC_WAKE_CYC,
  parameter int SUPPLY_CYC = STNDC_SUPPLY_CYC
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] bias_ratio_select,
  input wire logic [1:0] temp_comp_select,
  input wire logic [7:0] contrast_trim_value,
  input wire logic pump_source_bit,
  input wire logic [1:0] line_rate_field,
  input wire logic driver_enable_bit,
  input wire logic all_on_flag,
  input wire logic invert_flag,
  input wire logic onoff_mode,
  input wire logic partial_display_enable,
  input wire logic partial_scroll_bit,
  input wire logic [7:0] active_row_first,
  input wire logic [7:0] active_row_last,
  input wire logic [7:0] fixed_top_rows,
  input wire logic [7:0] fixed_bottom_rows,
  input wire logic [7:0] scroll_line_offset,
  input wire logic color_12bit_mode,
  input wire logic wr_valid,
  input wire logic [15:0] wr_pixel,
  input wire logic [COLS-1:0] ram_data,
  output logic ram_we,
  output logic [15:0] ram_word,
  output logic [7:0] ram_row,
  output logic [7:0] row_driver,
  output logic row_pulse,
  output logic [COLS-1:0] column_driver,
  output logic column_short,
  output logic sleep_state,
  output logic supply_on,
  output logic pump_internal,
  output logic [3:0] bias_ratio,
  output logic [4:0] temp_coeff,
  output logic [7:0] pump_level,
  output logic [7:0] mux_rate,
  output logic [4:0] line_div2,
  output logic frame_pulse
);
  // ----------------------------------------------------------------
  // lookup helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] base_period(input logic [1:0] code);
    case (code)
      2'd0: base_period = STNDC_LINE_P0;
      2'd1: base_period = STNDC_LINE_P1;
      2'd2: base_period = STNDC_LINE_P2;
      default: base_period = STNDC_LINE_P3;
    endcase
  endfunction

  // smallest threshold still at or above the mux carries the largest divide
  function automatic logic [3:0] mux_div2(input logic [7:0] mux);
    if (mux <= STNDC_THR_40) mux_div2 = STNDC_DIV2_4;
    else if (mux <= STNDC_THR_56) mux_div2 = STNDC_DIV2_3;
    else if (mux <= STNDC_THR_80) mux_div2 = STNDC_DIV2_2;
    else if (mux <= STNDC_THR_108) mux_div2 = STNDC_DIV2_15;
    else mux_div2 = STNDC_DIV2_1;
  endfunction

  // ----------------------------------------------------------------
  // power sequencing state
  // ----------------------------------------------------------------
  stndc_pwr_e pwr, next_pwr;
  logic [15:0] pwr_cnt, next_pwr_cnt;
  logic drivers_on;

  // wake, then supplies, then drivers; dropping enable always sleeps
  always_comb begin
    next_pwr = pwr;
    next_pwr_cnt = pwr_cnt;
    case (pwr)
      STNDC_SLEEP: begin
        next_pwr_cnt = 16'h0000;
        if (driver_enable_bit) begin
          next_pwr = STNDC_WAKE;
        end
      end
      STNDC_WAKE: begin
        next_pwr_cnt = pwr_cnt + 16'h0001;
        if (pwr_cnt == 16'(WAKE_CYC - 1)) begin
          next_pwr = STNDC_SUPPLY;
          next_pwr_cnt = 16'h0000;
        end
      end
      STNDC_SUPPLY: begin
        next_pwr_cnt = pwr_cnt + 16'h0001;
        if (pwr_cnt == 16'(SUPPLY_CYC - 1)) begin
          next_pwr = STNDC_ACTIVE;
        end
      end
      STNDC_ACTIVE: next_pwr_cnt = 16'h0000;
      default: next_pwr = STNDC_SLEEP;
    endcase
    if (!driver_enable_bit) begin
      next_pwr = STNDC_SLEEP;
      next_pwr_cnt = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pwr <= STNDC_SLEEP;
      pwr_cnt <= 16'h0000;
    end else begin
      pwr <= next_pwr;
      pwr_cnt <= next_pwr_cnt;
    end
  end

  assign drivers_on = (pwr == STNDC_ACTIVE);

  // ----------------------------------------------------------------
  // drive voltage settings
  // ----------------------------------------------------------------
  logic [3:0] next_bias;
  logic [4:0] next_tc;

  // analog generator takes decoded ratio, coefficient and trim code
  always_comb begin
    case (bias_ratio_select)
      2'd0: next_bias = STNDC_BIAS_0;
      2'd1: next_bias = STNDC_BIAS_1;
      2'd2: next_bias = STNDC_BIAS_2;
      default: next_bias = STNDC_BIAS_3;
    endcase
    case (temp_comp_select)
      2'd0: next_tc = STNDC_TC_0;
      2'd1: next_tc = STNDC_TC_1;
      2'd2: next_tc = STNDC_TC_2;
      default: next_tc = STNDC_TC_3;
    endcase
  end

  // pump runs internal whenever the source bit is clear, asleep or not; level always follows trim
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bias_ratio <= STNDC_BIAS_0;
      temp_coeff <= STNDC_TC_0;
      pump_level <= 8'h00;
      pump_internal <= 1'b0;
      supply_on <= 1'b0;
      sleep_state <= 1'b1;
    end else begin
      bias_ratio <= next_bias;
      temp_coeff <= next_tc;
      pump_level <= contrast_trim_value;
      pump_internal <= !pump_source_bit;
      supply_on <= (next_pwr == STNDC_SUPPLY) || (next_pwr == STNDC_ACTIVE);
      sleep_state <= (next_pwr == STNDC_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // mux rate and line timing
  // ----------------------------------------------------------------
  logic [7:0] next_mux;
  logic [8:0] fixed_sum;
  logic [9:0] span;
  logic [4:0] next_div2;
  logic [19:0] line_len;
  logic [19:0] line_cnt, next_line_cnt;
  logic [7:0] scan, next_scan;
  logic line_end;

  // partial mode narrows the scan to the active span
  always_comb begin
    fixed_sum = 9'(fixed_top_rows) + 9'(fixed_bottom_rows);
    span = 10'(active_row_last) - 10'(active_row_first) + 10'h001;
    if (partial_scroll_bit) begin
      span = span + 10'({fixed_sum, 1'b0});
    end
    if (!partial_display_enable) begin
      next_mux = STNDC_MUX_FULL;
    end else if (span > 10'(STNDC_MUX_FULL)) begin
      next_mux = STNDC_MUX_FULL;
    end else begin
      next_mux = span[7:0];
    end
    next_div2 = {1'b0, mux_div2(mux_rate)};
    // one spare bit: divide by four doubled in on/off mode reaches 16
    if (onoff_mode) begin
      next_div2 = 5'(next_div2 * 5'(STNDC_ONOFF_MUL));
    end
  end

  // line period = base * (div2 / 2); slower line, fewer transitions
  assign line_len = 20'(base_period(line_rate_field) * line_div2) >> 1;
  assign line_end = (line_cnt >= line_len - 20'h00001);

  // scan counter driven purely by the internal clock
  always_comb begin
    next_line_cnt = line_end ? 20'h00000 : line_cnt + 20'h00001;
    next_scan = scan;
    if (line_end) begin
      next_scan = (scan >= mux_rate - 8'h01) ? 8'h00 : scan + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mux_rate <= STNDC_MUX_FULL;
      line_div2 <= {1'b0, STNDC_DIV2_1};
      line_cnt <= 20'h00000;
      scan <= 8'h00;
    end else begin
      mux_rate <= next_mux;
      line_div2 <= next_div2;
      line_cnt <= next_line_cnt;
      scan <= next_scan;
    end
  end

  // ----------------------------------------------------------------
  // row selection and RAM row addressing
  // ----------------------------------------------------------------
  logic [7:0] phys_row;
  logic [8:0] scrolled;
  logic [7:0] next_ram_row;
  logic in_fixed;

  // physical row never moves; only RAM lookup scrolls
  always_comb begin
    phys_row = partial_display_enable ? 8'(active_row_first + scan) : scan;
    if (phys_row >= STNDC_MUX_FULL) begin
      phys_row = 8'(phys_row - STNDC_MUX_FULL);
    end
    in_fixed = (phys_row < fixed_top_rows) ||
               (9'(phys_row) >= 9'(STNDC_MUX_FULL) - 9'(fixed_bottom_rows));
    scrolled = 9'(phys_row) + 9'(scroll_line_offset);
    if (scrolled >= 9'(STNDC_MUX_FULL)) begin
      scrolled = scrolled - 9'(STNDC_MUX_FULL);
    end
    next_ram_row = in_fixed ? phys_row : scrolled[7:0];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      row_driver <= 8'h00;
      row_pulse <= 1'b0;
      ram_row <= 8'h00;
      frame_pulse <= 1'b0;
    end else begin
      row_driver <= phys_row;
      row_pulse <= drivers_on && line_end;
      ram_row <= next_ram_row;
      frame_pulse <= line_end && (next_scan == 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // datapath submodules (mode bits never rewrite stored RAM words)
  // ----------------------------------------------------------------
  stndc_seg_out #(.COLS(COLS)) u_seg (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .drivers_on(drivers_on),
    .all_on_flag(all_on_flag),
    .invert_flag(invert_flag),
    .ram_data(ram_data),
    .column_driver(column_driver),
    .column_short(column_short)
  );

  stndc_color_conv u_conv (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .color_12bit_mode(color_12bit_mode),
    .wr_valid(wr_valid),
    .wr_pixel(wr_pixel),
    .ram_we(ram_we),
    .ram_word(ram_word)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wake_start;
    pwr == STNDC_SLEEP && driver_enable_bit;
  endsequence

  AST_SLEEP_DROP: assert property (@(posedge sys_clk) disable iff (!rstn)
    !driver_enable_bit |=> pwr == STNDC_SLEEP && sleep_state)
    else $error("enable low did not sleep");
  AST_WAKE_ORDER: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_wake_start |=> pwr == STNDC_WAKE && !supply_on)
    else $error("wake did not precede supplies");
  AST_DRV_AFTER_SUPPLY: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(drivers_on) |-> $past(pwr) == STNDC_SUPPLY)
    else $error("drivers on before supply");
  AST_BIAS_MAP: assert property (@(posedge sys_clk) disable iff (!rstn)
    bias_ratio_select == 2'd1 |=> bias_ratio == STNDC_BIAS_1)
    else $error("bias map wrong");
  AST_TC_MAP: assert property (@(posedge sys_clk) disable iff (!rstn)
    temp_comp_select == 2'd3 |=> temp_coeff == STNDC_TC_3)
    else $error("temp coeff map wrong");
  AST_PUMP_SRC: assert property (@(posedge sys_clk) disable iff (!rstn)
    pump_source_bit |=> !pump_internal)
    else $error("pump source wrong");
  AST_TRIM: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> pump_level == $past(contrast_trim_value))
    else $error("trim not passed");
  AST_DIV_HIGH: assert property (@(posedge sys_clk) disable iff (!rstn)
    mux_rate >= STNDC_THR_109 && !onoff_mode |=> line_div2 == STNDC_DIV2_1)
    else $error("scaled above threshold");
  AST_DIV_40: assert property (@(posedge sys_clk) disable iff (!rstn)
    mux_rate <= STNDC_THR_40 && !onoff_mode |=> line_div2 == STNDC_DIV2_4)
    else $error("divide by four missing");
  AST_ONOFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    onoff_mode && mux_rate >= STNDC_THR_109 |=> line_div2 == STNDC_DIV2_2)
    else $error("on/off did not slow line");
  AST_MUX_FULL: assert property (@(posedge sys_clk) disable iff (!rstn)
    !partial_display_enable |=> mux_rate == STNDC_MUX_FULL)
    else $error("full mux wrong");
  AST_ROW_FIXED: assert property (@(posedge sys_clk) disable iff (!rstn)
    row_driver < STNDC_MUX_FULL)
    else $error("row index out of range");
endmodule

// ==== bench/stndc_panel.sv ====
// panel side: presents the row image and counts scanned lines
module stndc_panel
  import stndc_pkg::*;
#(
  parameter int COLS = 8
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic row_pulse,
  input wire logic column_short,
  input wire logic [COLS-1:0] column_driver,
  input wire logic [COLS-1:0] image,
  output logic [COLS-1:0] ram_data,
  output int rows_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // image row handed back as read data
  assign ram_data = image;
  // shorted columns carry no charge, so those lines are not counted
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rows_seen <= 0;
    end else if (row_pulse && !column_short) begin
      rows_seen <= rows_seen + 1;
    end
  end
endmodule

// ==== bench/stndc_top_tb_top.sv ====
module stndc_top_tb_top;
  import stndc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WK = 4;
  localparam int SP = 8;
  logic sys_clk, rstn, pump_source_bit, driver_enable_bit, all_on_flag, invert_flag;
  logic onoff_mode, partial_display_enable, partial_scroll_bit, color_12bit_mode, wr_valid;
  logic [1:0] bias_ratio_select, temp_comp_select, line_rate_field;
  logic [7:0] contrast_trim_value, active_row_first, active_row_last, fixed_top_rows;
  logic [7:0] fixed_bottom_rows, scroll_line_offset, img, ram_data, ram_row, row_driver;
  logic [15:0] wr_pixel, ram_word;
  logic ram_we, row_pulse, column_short, sleep_state, supply_on, pump_internal, frame_pulse;
  logic [7:0] column_driver, pump_level, mux_rate;
  logic [3:0] bias_ratio;
  logic [4:0] line_div2;
  logic [4:0] temp_coeff;
  int num_errors = 0;
  int tests_run = 0;
  int rows_seen, n, m;
  logic [3:0] bias_t [4] = '{STNDC_BIAS_0, STNDC_BIAS_1, STNDC_BIAS_2, STNDC_BIAS_3};
  logic [4:0] tc_t [4] = '{STNDC_TC_0, STNDC_TC_1, STNDC_TC_2, STNDC_TC_3};
  logic [11:0] per_t [4] = '{STNDC_LINE_P0, STNDC_LINE_P1, STNDC_LINE_P2, STNDC_LINE_P3};
  int edge_t [8] = '{109, 108, 81, 80, 57, 56, 41, 40};

  stndc_top #(.COLS(8), .WAKE_CYC(WK), .SUPPLY_CYC(SP)) stndc_top_inst (
    .sys_clk, .rstn, .bias_ratio_select, .temp_comp_select, .contrast_trim_value,
    .pump_source_bit, .line_rate_field, .driver_enable_bit, .all_on_flag, .invert_flag,
    .onoff_mode, .partial_display_enable, .partial_scroll_bit, .active_row_first,
    .active_row_last, .fixed_top_rows, .fixed_bottom_rows, .scroll_line_offset,
    .color_12bit_mode, .wr_valid, .wr_pixel, .ram_data, .ram_we, .ram_word, .ram_row,
    .row_driver, .row_pulse, .column_driver, .column_short, .sleep_state, .supply_on,
    .pump_internal, .bias_ratio, .temp_coeff, .pump_level, .mux_rate, .line_div2,
    .frame_pulse);
  stndc_panel #(.COLS(8)) stndc_panel_inst (.sys_clk, .rstn, .row_pulse, .column_short,
    .column_driver, .image(img), .ram_data, .rows_seen);

  // ----------------------------------------------------------------
  // reference model and helpers
  // ----------------------------------------------------------------
  function automatic int mux_m(logic p, logic s, int f, int l, int t, int b);
    int r;
    r = p ? (l - f + 1 + (s ? (t + b) * 2 : 0)) : 160;
    return (r > 160) ? 160 : r;
  endfunction
  // divisor in half steps; on/off mode doubles it
  function automatic int div_m(int r, logic oo);
    int d;
    d = (r > 108) ? 2 : (r > 80) ? 3 : (r > 56) ? 4 : (r > 40) ? 6 : 8;
    return oo ? d * 2 : d;
  endfunction
  // RAM row for a physical row: fixed regions skip the scroll offset
  function automatic int row_m(int r);
    if (r < fixed_top_rows || r >= 160 - fixed_bottom_rows) return r;
    return (r + scroll_line_offset) % 160;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // drives one partial setting and compares mux and divisor
  task automatic mux_case(logic p, logic s, int f, int l, int t, int b, logic oo);
    @(posedge sys_clk);
    partial_display_enable <= p;
    partial_scroll_bit <= s;
    active_row_first <= 8'(f);
    active_row_last <= 8'(l);
    fixed_top_rows <= 8'(t);
    fixed_bottom_rows <= 8'(b);
    onoff_mode <= oo;
    m = mux_m(p, s, f, l, t, b);
    step(3);
    check("mux_rate", 16'(mux_rate), 16'(m));
    check("line_div2", 16'(line_div2), 16'(div_m(m, oo)));
  endtask
  // cycles between two row pulses, bounded
  task automatic line_gap(output int g);
    int k;
    k = 0;
    do begin @(negedge sys_clk); k++; end while (row_pulse !== 1'b1 && k < 3000);
    g = 0;
    do begin @(negedge sys_clk); g++; end while (row_pulse !== 1'b1 && g < 3000);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  // the whole run needs well under 20k cycles
  initial begin
    #8ms;
    num_errors++;
    close_out();
  end
  initial begin
    {rstn, pump_source_bit, driver_enable_bit, all_on_flag, invert_flag} = '0;
    {onoff_mode, partial_display_enable, partial_scroll_bit, color_12bit_mode} = '0;
    {wr_valid, bias_ratio_select, temp_comp_select, line_rate_field} = '0;
    {contrast_trim_value, active_row_first, active_row_last, fixed_top_rows} = '0;
    {fixed_bottom_rows, scroll_line_offset, img, wr_pixel} = '0;
    void'($urandom(32'hbdc39b05));
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    check("sleep_rst", 16'(sleep_state), 16'h1);
    check("short_rst", 16'(column_short), 16'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      bias_ratio_select <= 2'(i);
      temp_comp_select <= 2'(3 - i);
      pump_source_bit <= i[0];
      contrast_trim_value <= 8'($urandom);
      scroll_line_offset <= 8'($urandom);
      step(2);
      check("bias_ratio", 16'(bias_ratio), 16'(bias_t[i]));
      check("pump_level", 16'(pump_level), 16'(contrast_trim_value));
      check("temp_coeff", 16'(temp_coeff), 16'(tc_t[3 - i]));
      check("pump_internal", 16'(pump_internal), 16'(!i[0]));
    end
    // boundary spans, then random partial settings
    foreach (edge_t[i]) for (int o = 0; o < 2; o++) mux_case(1, 0, 0, edge_t[i] - 1, 0, 0, o[0]);
    repeat (12) begin
      mux_case($urandom, $urandom, $urandom % 90, 90 + $urandom % 70,
        $urandom % 12, $urandom % 12, 0);
      mux_case(partial_display_enable, partial_scroll_bit, active_row_first,
        active_row_last, fixed_top_rows, fixed_bottom_rows, 1);
    end
    mux_case(0, 0, 0, 0, 0, 0, 0);
    // pixel writes in the default mode, then 12-bit, then back again
    for (int c = 0; c < 3; c++) begin
      repeat (4) begin
        @(posedge sys_clk);
        color_12bit_mode <= (c == 1);
        wr_valid <= 1'b1;
        wr_pixel <= 16'($urandom);
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        @(negedge sys_clk);
        check("ram_we", 16'(ram_we), 16'h1);
        if (c == 1) check("ram_word", ram_word, {wr_pixel[11:8], wr_pixel[11], wr_pixel[7:4],
          wr_pixel[7:6], wr_pixel[3:0], wr_pixel[3]});
        else check("ram_word", ram_word, wr_pixel);
        @(negedge sys_clk);
        check("ram_we_end", 16'(ram_we), 16'h0);
      end
    end
    // wake sequence: supplies back before the columns are released
    @(posedge sys_clk);
    driver_enable_bit <= 1'b1;
    step(1);
    check("sleep_exit", 16'(sleep_state), 16'h0);
    n = 0;
    while (column_short !== 1'b0 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    check("supply_first", 16'(supply_on), 16'h1);
    check("wake_len", 16'(n >= WK + SP), 16'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      img <= 8'($urandom);
      all_on_flag <= (i == 1);
      invert_flag <= (i == 2);
      step(3);
      check("column_driver", 16'(column_driver),
        16'(8'((i == 1) ? 8'hff : (i == 2) ? ~img : img)));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      line_rate_field <= 2'(i);
      fixed_top_rows <= 8'(40 * i);
      line_gap(n);
      line_gap(n);
      check("line_period", 16'(n), 16'(per_t[i]));
      check("ram_row", 16'(ram_row), 16'(row_m(row_driver)));
      check("row_range", 16'(row_driver < 8'd160), 16'h1);
    end
    check("rows_seen", 16'(rows_seen > 0), 16'h1);
    @(posedge sys_clk);
    driver_enable_bit <= 1'b0;
    all_on_flag <= 1'b1;
    step(2);
    check("sleep_enter", 16'(sleep_state), 16'h1);
    check("short_idle", 16'(column_short), 16'h1);
    check("idle_columns", 16'(column_driver), 16'h0);
    close_out();
  end
endmodule
